//--- inc/htc_cfg.svh
// constants for the hysteresis threshold comparator
`ifndef HTC_CFG_SVH
`define HTC_CFG_SVH
`define HTC_DATA_W 32
`define HTC_FMT_W 2
`define HTC_FMT_WORD 2'h0
`define HTC_FMT_INT 2'h1
`define HTC_FMT_DWORD 2'h2
`define HTC_FMT_LONG 2'h3
`define HTC_FMT_DEFAULT 2'h1
`define HTC_OUT_RST 1'h0
`endif

//--- inc/htc_pkg.sv
// types for the hysteresis threshold comparator
`default_nettype none
`include "htc_cfg.svh"
package htc_pkg;
	typedef enum logic [1:0] {
		HTC_WORD = 2'h0,
		HTC_INT = 2'h1,
		HTC_DWORD = 2'h2,
		HTC_LONG = 2'h3
	} htc_fmt_t;
	typedef struct packed {
		logic [`HTC_DATA_W-1:0] value;
		logic [`HTC_DATA_W-1:0] on_thr;
		logic [`HTC_DATA_W-1:0] off_thr;
	} htc_ops_t;
	typedef struct packed {
		logic value;
		logic on_thr;
		logic off_thr;
	} htc_conn_t;
endpackage
`default_nettype wire

//--- hw/htc_operand_norm.sv
// operand normaliser: zero for unconnected, widen per format
`timescale 1ns/100ps
`default_nettype none
`include "htc_cfg.svh"
module htc_operand_norm
	import htc_pkg::*;
(
	input wire logic [`HTC_DATA_W-1:0] raw,
	input wire logic connected,
	input wire htc_fmt_t fmt,
	output logic [`HTC_DATA_W:0] ext
);
	logic [`HTC_DATA_W-1:0] v;
	always_comb begin
		v = connected ? raw : {`HTC_DATA_W{1'h0}}; // R9
		case (fmt) // R10 R16
			HTC_WORD: ext = {17'h00000, v[15:0]};
			HTC_INT: ext = {{17{v[15]}}, v[15:0]};
			HTC_DWORD: ext = {1'h0, v};
			HTC_LONG: ext = {v[31], v};
			default: ext = {1'h0, v};
		endcase
	end
endmodule
`default_nettype wire

//--- hw/htc_top.sv
// hysteresis / window threshold comparator
`timescale 1ns/100ps
`default_nettype none
`include "htc_cfg.svh"
// Behaviour
// (R1) While enabled, the value is compared against both thresholds each cycle.
// (R2) While disabled, the output is forced low.
// (R3) On threshold at or above off threshold gives hysteresis, otherwise window.
// (R4) In hysteresis the output goes high when the value is above the on threshold.
// (R5) In hysteresis the output goes low when the value is at or below the off threshold.
// (R6) In hysteresis between the thresholds the output holds its last value.
// (R7) In window the output is high when on threshold <= value <= off threshold.
// (R8) In window the output is low when the value is outside that range.
// (R9) An unconnected operand is taken as zero.
// (R10) The format is word, integer, double word or long, integer by default; the normaliser's default branch zero-extends as double word.
// (R11) Word operands stay within 0 to 65535, kept by the supplier.
// (R12) Integer operands stay within the signed 16-bit range, kept by the supplier.
// (R13) Double word operands stay within 0 to 4294967295, kept by the supplier.
// (R14) Long operands stay within the signed 32-bit range, kept by the supplier.
// (R15) An analog source feeds operands only in the formats its variant permits.
// (R16) Integer and long compare signed, word and double word unsigned, once a cycle.
module htc_top
	import htc_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic enable,
	input wire htc_fmt_t operand_format_select,
	input wire htc_ops_t ops,
	input wire htc_conn_t conn,
	output logic out_bit
);
	// ----------------------------------------
	// operand normalisation
	// ----------------------------------------
	logic [`HTC_DATA_W:0] val_x;
	logic [`HTC_DATA_W:0] on_x;
	logic [`HTC_DATA_W:0] off_x;
	htc_operand_norm u_val (
		.raw(ops.value), .connected(conn.value), .fmt(operand_format_select), .ext(val_x)
	);
	htc_operand_norm u_on (
		.raw(ops.on_thr), .connected(conn.on_thr), .fmt(operand_format_select), .ext(on_x)
	);
	htc_operand_norm u_off (
		.raw(ops.off_thr), .connected(conn.off_thr), .fmt(operand_format_select), .ext(off_x)
	);

	// signed compare of zero- or sign-extended values covers all formats
	function automatic logic gt_f(input logic [`HTC_DATA_W:0] a, input logic [`HTC_DATA_W:0] b);
		gt_f = $signed(a) > $signed(b);
	endfunction

	// inclusive band test shared by decision and checks
	function automatic logic in_window_f(
		input logic [`HTC_DATA_W:0] v,
		input logic [`HTC_DATA_W:0] lo,
		input logic [`HTC_DATA_W:0] hi
	);
		in_window_f = !gt_f(lo, v) && !gt_f(v, hi);
	endfunction

	// ----------------------------------------
	// decision
	// ----------------------------------------
	logic out_ff;
	logic nxt_out;
	logic hyst_mode;
	always_comb begin
		hyst_mode = !gt_f(off_x, on_x); // R3
		nxt_out = out_ff;
		if (!enable) begin
			nxt_out = 1'h0; // R2
		end else if (hyst_mode) begin // R1
			if (gt_f(val_x, on_x)) begin
				nxt_out = 1'h1; // R4
			end else if (!gt_f(val_x, off_x)) begin
				nxt_out = 1'h0; // R5
			end else begin
				nxt_out = out_ff; // R6
			end
		end else begin
			nxt_out = in_window_f(val_x, on_x, off_x); // R7 R8
		end
	end
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			out_ff <= `HTC_OUT_RST;
		end else begin
			out_ff <= nxt_out; // R16
		end
	end
	assign out_bit = out_ff;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_dis_low;
		@(posedge mclk) disable iff (!rst_n) !enable |=> !out_bit;
	endproperty
	a_dis_low: assert property (p_dis_low) else $error("output high after disable"); // R2
	property p_hyst_on;
		@(posedge mclk) disable iff (!rst_n)
		(enable && hyst_mode && gt_f(val_x, on_x)) |=> out_bit;
	endproperty
	a_hyst_on: assert property (p_hyst_on) else $error("hysteresis did not turn on"); // R4
	property p_hyst_off;
		@(posedge mclk) disable iff (!rst_n)
		(enable && hyst_mode && !gt_f(val_x, off_x)) |=> !out_bit;
	endproperty
	a_hyst_off: assert property (p_hyst_off) else $error("hysteresis did not turn off"); // R5
	property p_hyst_hold;
		@(posedge mclk) disable iff (!rst_n)
		(enable && hyst_mode && gt_f(val_x, off_x) && !gt_f(val_x, on_x))
		|=> out_bit == $past(out_bit);
	endproperty
	a_hyst_hold: assert property (p_hyst_hold) else $error("hysteresis hold broken"); // R6
	property p_win_in;
		@(posedge mclk) disable iff (!rst_n)
		(enable && gt_f(off_x, on_x) && !gt_f(on_x, val_x) && !gt_f(val_x, off_x)) |=> out_bit;
	endproperty
	a_win_in: assert property (p_win_in) else $error("window inside not high"); // R7
	property p_win_out;
		@(posedge mclk) disable iff (!rst_n)
		(enable && gt_f(off_x, on_x) && (gt_f(on_x, val_x) || gt_f(val_x, off_x))) |=> !out_bit;
	endproperty
	a_win_out: assert property (p_win_out) else $error("window outside not low"); // R8
	property p_mode;
		@(posedge mclk) disable iff (!rst_n) hyst_mode == !gt_f(off_x, on_x);
	endproperty
	a_mode: assert property (p_mode) else $error("mode select wrong"); // R3
	property p_rise_cause;
		@(posedge mclk) disable iff (!rst_n) $rose(out_bit) |-> $past(enable);
	endproperty
	a_rise_cause: assert property (p_rise_cause) else $error("rise without enable"); // R1
	property p_rise_why;
		@(posedge mclk) disable iff (!rst_n)
		$rose(out_bit)
		|-> $past(enable && (hyst_mode ? gt_f(val_x, on_x) : in_window_f(val_x, on_x, off_x)));
	endproperty
	a_rise_why: assert property (p_rise_why) else $error("rise without a reason"); // R4 R7
	property p_fall_why;
		@(posedge mclk) disable iff (!rst_n)
		$fell(out_bit)
		|-> $past(!rst_n || !enable
			|| (hyst_mode ? !gt_f(val_x, off_x) : !in_window_f(val_x, on_x, off_x)));
	endproperty
	a_fall_why: assert property (p_fall_why) else $error("fall without a reason"); // R5 R8
	property p_zero_val;
		@(posedge mclk) disable iff (!rst_n) !conn.value |-> val_x == 33'h000000000;
	endproperty
	a_zero_val: assert property (p_zero_val) else $error("unconnected value not zero"); // R9
	property p_int_sign;
		@(posedge mclk) disable iff (!rst_n)
		(operand_format_select == HTC_INT && conn.value && ops.value[15]) |-> val_x[32];
	endproperty
	a_int_sign: assert property (p_int_sign) else $error("integer not signed"); // R16

	// ----------------------------------------
	// assertions: unconnected operands and operand formats
	// ----------------------------------------
	property p_zero_on;
		@(posedge mclk) disable iff (!rst_n)
		!conn.on_thr |-> on_x == 33'h000000000;
	endproperty
	a_zero_on: assert property (p_zero_on) else $error("unconnected on threshold not zero"); // R9
	property p_zero_off;
		@(posedge mclk) disable iff (!rst_n)
		!conn.off_thr |-> off_x == 33'h000000000;
	endproperty
	a_zero_off: assert property (p_zero_off) else $error("unconnected off threshold not zero"); // R9
	property p_zero_all;
		@(posedge mclk) disable iff (!rst_n)
		(enable && !conn.value && !conn.on_thr && !conn.off_thr) |=> !out_bit;
	endproperty
	a_zero_all: assert property (p_zero_all) else $error("all unconnected not low"); // R9
	property p_word_ext;
		@(posedge mclk) disable iff (!rst_n)
		operand_format_select == HTC_WORD
		|-> val_x[32:16] == 17'h00000 && on_x[32:16] == 17'h00000 && off_x[32:16] == 17'h00000;
	endproperty
	a_word_ext: assert property (p_word_ext) else $error("word operand not zero extended"); // R16
	property p_int_ext;
		@(posedge mclk) disable iff (!rst_n)
		operand_format_select == HTC_INT
		|-> val_x[32:16] == {17{val_x[15]}} && on_x[32:16] == {17{on_x[15]}}
			&& off_x[32:16] == {17{off_x[15]}};
	endproperty
	a_int_ext: assert property (p_int_ext) else $error("integer operand not sign extended"); // R16
	property p_dword_ext;
		@(posedge mclk) disable iff (!rst_n)
		operand_format_select == HTC_DWORD
		|-> !val_x[32] && !on_x[32] && !off_x[32];
	endproperty
	a_dword_ext: assert property (p_dword_ext) else $error("double word operand signed"); // R16
	property p_long_ext;
		@(posedge mclk) disable iff (!rst_n)
		operand_format_select == HTC_LONG
		|-> val_x[32] == val_x[31] && on_x[32] == on_x[31] && off_x[32] == off_x[31];
	endproperty
	a_long_ext: assert property (p_long_ext) else $error("long operand not sign extended"); // R16
	property p_word_pass;
		@(posedge mclk) disable iff (!rst_n)
		(operand_format_select == HTC_WORD && conn.value)
		|-> val_x[15:0] == ops.value[15:0];
	endproperty
	a_word_pass: assert property (p_word_pass) else $error("word value not passed"); // R10
	property p_long_pass;
		@(posedge mclk) disable iff (!rst_n)
		(operand_format_select == HTC_LONG && conn.on_thr)
		|-> on_x[31:0] == ops.on_thr;
	endproperty
	a_long_pass: assert property (p_long_pass) else $error("long threshold not passed"); // R10

	// ----------------------------------------
	// cover points
	// ----------------------------------------
	c_hyst_hold: cover property (@(posedge mclk) disable iff (!rst_n)
		enable && hyst_mode && out_bit ##1 enable && out_bit);
	c_win_on: cover property (@(posedge mclk) disable iff (!rst_n)
		enable && !hyst_mode ##1 out_bit);
	c_dis: cover property (@(posedge mclk) disable iff (!rst_n) out_bit ##1 !enable ##1 !out_bit);
	c_win_off: cover property (@(posedge mclk) disable iff (!rst_n)
		enable && !hyst_mode && out_bit ##1 !out_bit);
	c_hyst_fall: cover property (@(posedge mclk) disable iff (!rst_n)
		enable && hyst_mode && out_bit ##1 !out_bit);
endmodule
`default_nettype wire

//--- tb/test_htc_top.sv
// self-checking bench for the hysteresis threshold comparator
`timescale 1ns/100ps
`default_nettype none
module test_htc_top
	import htc_pkg::*;
;
	localparam int NCYC = 2000;
	// set before any process starts, so no false falling edge at time zero
	logic mclk = 1'h0;
	logic rst_n, enable, out_bit, exp_bit, got;
	htc_fmt_t fmt;
	htc_ops_t ops;
	htc_conn_t conn;
	logic exp_q[$];
	int fails, samples_checked, seed;

	htc_top DUT (
		.mclk(mclk), .rst_n(rst_n), .enable(enable), .operand_format_select(fmt),
		.ops(ops), .conn(conn), .out_bit(out_bit)
	);

	function automatic logic signed [32:0] widen(logic [31:0] v, logic c, htc_fmt_t f);
		if (!c) return 33'sh0;
		case (f)
			HTC_WORD: return {17'h0, v[15:0]};
			HTC_INT: return {{17{v[15]}}, v[15:0]};
			HTC_DWORD: return {1'h0, v};
			default: return {v[31], v};
		endcase
	endfunction

	// small values around zero, kept legal for the format
	function automatic logic [31:0] pick(logic [2:0] k, htc_fmt_t f);
		logic [31:0] s;
		s = {{29{k[2]}}, k};
		return (f == HTC_WORD) ? {16'h0, s[15:0]} : s;
	endfunction

	task automatic stop_test();
		if (fails == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		mclk = 1'h0;
		forever #10 mclk = ~mclk;
	end

	// ----------------------------------------
	// stimulus and expected output
	// ----------------------------------------
	initial begin
		logic signed [32:0] a, on, off;
		logic [31:0] r;
		seed = 32'h48C1;
		fails = 0;
		samples_checked = 0;
		exp_bit = 1'h0;
		for (int i = 0; i < NCYC; i++) begin
			r = $random(seed);
			rst_n = !(i < 3 || i == 900);
			enable = |r[2:0];
			fmt = htc_fmt_t'(r[4:3]);
			conn = {|r[6:5], |r[8:7], |r[10:9]};
			ops = {pick(r[13:11], fmt), pick(r[16:14], fmt), pick(r[19:17], fmt)};
			a = widen(ops.value, conn.value, fmt);
			on = widen(ops.on_thr, conn.on_thr, fmt);
			off = widen(ops.off_thr, conn.off_thr, fmt);
			if (!rst_n || !enable) begin
				exp_bit = 1'h0;
			end else if (on >= off) begin
				if (a > on) begin
					exp_bit = 1'h1;
				end else if (a <= off) begin
					exp_bit = 1'h0;
				end
			end else begin
				exp_bit = (a >= on && a <= off);
			end
			exp_q.push_back(exp_bit);
			@(negedge mclk);
		end
		@(posedge mclk);
		#2;
		stop_test();
	end

	// ----------------------------------------
	// output watcher
	// ----------------------------------------
	always @(posedge mclk) begin
		#1;
		if (exp_q.size() > 0) begin
			got = exp_q.pop_front();
			samples_checked++;
			if (out_bit !== got) begin
				fails++;
				$display("BAD out_bit expected %b seen %b", got, out_bit);
			end
		end
	end

	initial begin
		#(NCYC * 20 + 2000);
		fails++;
		stop_test();
	end
endmodule
`default_nettype wire
